// File: verilog/apc_regs.svh
// timing counts and field positions for the conversion control block
`ifndef APC_REGS_SVH
`define APC_REGS_SVH
`define APC_CLK_PERIOD_PS   4000
`define APC_CONV_TYP_PS     2450000
`define APC_CONV_MAX_PS     2700000
`define APC_ACQ_MIN_PS      600000
`define APC_CONV_CYCLES     (`APC_CONV_MAX_PS / `APC_CLK_PERIOD_PS)
`define APC_ACQ_CYCLES      ((`APC_ACQ_MIN_PS + `APC_CLK_PERIOD_PS - 1) / `APC_CLK_PERIOD_PS)
`define APC_CNT_W           10
`define APC_RES_W           12
`define APC_BUS_W           16
`define APC_LOW_BYTE_MSB    7
`define APC_NIB_LSB         8
`define APC_NIB_MSB         11
`endif

// File: verilog/apc_pkg.sv
// types shared by the conversion control block
package apc_pkg;
  typedef enum logic [1:0] {APC_IDLE, APC_CONVERT, APC_ACQUIRE} apc_state_type;
  typedef enum logic {APC_STALL_READ, APC_PIPE_READ} apc_mode_type;
endpackage

// File: verilog/apc_pin_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
module apc_pin_sync
(
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  input  wire logic reset_val_in,
  input  wire logic pin_in,
  output var  logic level_out
);
  logic s1_reg;     // first stage, read only by s2
  logic s2_reg;     // second stage
  logic s3_reg;     // third stage
  logic lvl_reg;    // filtered level
  logic s1_next;
  logic s2_next;
  logic s3_next;
  logic lvl_next;

  // shift chain and agreement filter
  always_comb
  begin
    s1_next  = pin_in;
    s2_next  = s1_reg;
    s3_next  = s2_reg;
    lvl_next = (s2_reg == s3_reg) ? s2_reg : lvl_reg;
  end

  // registers, reset to the pin's idle level so no false change follows reset
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      s1_reg  <= reset_val_in;
      s2_reg  <= reset_val_in;
      s3_reg  <= reset_val_in;
      lvl_reg <= reset_val_in;
    end
    else if (ce_in)
    begin
      s1_reg  <= s1_next;
      s2_reg  <= s2_next;
      s3_reg  <= s3_next;
      lvl_reg <= lvl_next;
    end
  end
  assign level_out = lvl_reg;
endmodule
`default_nettype wire

// File: verilog/apc_control.sv
// conversion start, busy and parallel readout control of a 12-bit converter
// What this block does
// - start needs select, strobe, byte select low
// - starts ignored while a conversion runs
// - busy low during conversion, high otherwise
// - conversion takes at most 2.7 us
// - acquisition gap of 600 ns
// - stall mode read starts, host waits
// - pipelined read starts, returns previous result
// - result right justified, lsb on bit 0
// - byte select steers result to low byte
// - upper nibble pins always carry top bits
// - busy low on start, old data shown
// - latch updates in the same cycle busy returns high
// - high byte read: nibble low, zeros, no start
// - next pipelined read returns new result
// - pipelined high byte read starts nothing
// - result coding passes through unchanged
`timescale 1ns/1ps
`default_nettype none
`include "apc_regs.svh"
module apc_control
(
  input  wire logic                   mclk_in,
  input  wire logic                   rst_in,
  input  wire logic                   ce_in,
  input  wire logic                   chip_select_low_in,
  input  wire logic                   read_strobe_low_in,
  input  wire logic                   high_byte_select_in,
  input  wire logic                   pipelined_read_mode_in,
  input  wire logic [`APC_RES_W-1:0]  result_bits_in,
  output var  logic                   busy_low_out,
  output var  logic                   sample_out,
  output var  logic [`APC_BUS_W-1:0]  data_out,
  output var  logic [`APC_BUS_W-1:0]  data_oe_out
);
  logic cs_low;     // synchronised chip select
  logic rd_low;     // synchronised read strobe
  logic hb_sel;     // synchronised byte select

  // pin synchronisers for chip select, read strobe and byte select
  apc_pin_sync u_sync_cs
  (
    .mclk_in      (mclk_in),
    .rst_in       (rst_in),
    .ce_in        (ce_in),
    .reset_val_in (1'b1),
    .pin_in       (chip_select_low_in),
    .level_out    (cs_low)
  );
  apc_pin_sync u_sync_rd
  (
    .mclk_in      (mclk_in),
    .rst_in       (rst_in),
    .ce_in        (ce_in),
    .reset_val_in (1'b1),
    .pin_in       (read_strobe_low_in),
    .level_out    (rd_low)
  );
  apc_pin_sync u_sync_hb
  (
    .mclk_in      (mclk_in),
    .rst_in       (rst_in),
    .ce_in        (ce_in),
    .reset_val_in (1'b0),
    .pin_in       (high_byte_select_in),
    .level_out    (hb_sel)
  );

  // read access decode, shared by start and output logic
  function automatic logic access_on(input logic cs_l, input logic rd_l);
    access_on = !cs_l && !rd_l;
  endfunction

  apc_pkg::apc_state_type        state_reg;    // sequencer state
  apc_pkg::apc_state_type        state_next;
  logic [`APC_CNT_W-1:0]         cnt_reg;      // cycle counter
  logic [`APC_CNT_W-1:0]         cnt_next;
  logic [`APC_RES_W-1:0]         latch_reg;    // output latch
  logic [`APC_RES_W-1:0]         latch_next;
  logic                          armed_reg;    // access not yet used to start
  logic                          armed_next;
  logic                          busy_l_reg;
  logic                          busy_l_next;
  logic                          sample_reg;   // pulse capturing the result
  logic                          sample_next;
  logic [`APC_BUS_W-1:0]         data_reg;
  logic [`APC_BUS_W-1:0]         data_next;
  logic [`APC_BUS_W-1:0]         oe_reg;
  logic [`APC_BUS_W-1:0]         oe_next;
  logic                          access;
  logic                          start_req;
  logic                          stall_wait;

  // sequencer: start gating, conversion timer, acquisition gap
  always_comb
  begin
    access      = access_on(cs_low, rd_low);
    start_req   = access && !hb_sel && armed_reg;
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    latch_next  = latch_reg;
    busy_l_next = busy_l_reg;
    sample_next = 1'b0;
    armed_next  = access ? armed_reg : 1'b1;
    unique case (state_reg)
      apc_pkg::APC_IDLE:
      begin
        if (start_req)
        begin
          state_next  = apc_pkg::APC_CONVERT;
          cnt_next    = `APC_CNT_W'(`APC_CONV_CYCLES - 1);
          busy_l_next = 1'b0;
          armed_next  = 1'b0;
        end
      end
      apc_pkg::APC_CONVERT:
      begin
        // further starts ignored here
        if (cnt_reg == `APC_CNT_W'(0))
        begin
          latch_next  = result_bits_in;
          sample_next = 1'b1;
          busy_l_next = 1'b1;
          state_next  = apc_pkg::APC_ACQUIRE;
          cnt_next    = `APC_CNT_W'(`APC_ACQ_CYCLES - 1);
        end
        else
        begin
          cnt_next = cnt_reg - `APC_CNT_W'(1);
        end
      end
      apc_pkg::APC_ACQUIRE:
      begin
        if (cnt_reg == `APC_CNT_W'(0))
        begin
          state_next = apc_pkg::APC_IDLE;
        end
        else
        begin
          cnt_next = cnt_reg - `APC_CNT_W'(1);
        end
      end
      default:
      begin
        state_next = apc_pkg::APC_IDLE;
      end
    endcase
  end

  // output drive: byte steering, enables, stall-mode hold of old data
  always_comb
  begin
    stall_wait = !pipelined_read_mode_in && (state_reg == apc_pkg::APC_CONVERT);
    data_next  = `APC_BUS_W'(0);
    oe_next    = `APC_BUS_W'(0);
    if (access)
    begin
      oe_next[`APC_NIB_MSB:0] = {`APC_RES_W{1'b1}};
      if (hb_sel)
      begin
        data_next[3:0] = latch_reg[`APC_NIB_MSB:`APC_NIB_LSB];
        data_next[`APC_LOW_BYTE_MSB:4] = 4'h0;
      end
      else
      begin
        data_next[`APC_LOW_BYTE_MSB:0] = latch_reg[`APC_LOW_BYTE_MSB:0];
      end
      data_next[`APC_NIB_MSB:`APC_NIB_LSB] = latch_reg[`APC_NIB_MSB:`APC_NIB_LSB];
    end
    // latch holds the previous result until conversion end, so old data shows
    // on the bus while a stalled host waits
  end

  // state registers
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state_reg  <= apc_pkg::APC_IDLE;
      cnt_reg    <= `APC_CNT_W'(0);
      latch_reg  <= `APC_RES_W'(0);
      armed_reg  <= 1'b1;
      busy_l_reg <= 1'b1;
      sample_reg <= 1'b0;
      data_reg   <= `APC_BUS_W'(0);
      oe_reg     <= `APC_BUS_W'(0);
    end
    else if (ce_in)
    begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      latch_reg  <= latch_next;
      armed_reg  <= armed_next;
      busy_l_reg <= busy_l_next;
      sample_reg <= sample_next;
      data_reg   <= data_next;
      oe_reg     <= oe_next;
    end
  end

  assign busy_low_out = busy_l_reg;
  assign sample_out   = sample_reg;
  assign data_out     = data_reg;
  assign data_oe_out  = oe_reg;

  // checks
  a_busy_tracks_state: assert property (@(posedge mclk_in) disable iff (rst_in)
    busy_l_reg == (state_reg != apc_pkg::APC_CONVERT))
    else $error("busy level wrong");
  a_start_gate: assert property (@(posedge mclk_in) disable iff (rst_in)
    (ce_in && state_reg == apc_pkg::APC_IDLE && !(access && !hb_sel)) |=> state_reg != apc_pkg::APC_CONVERT)
    else $error("start without all three low");
  a_start_busy: assert property (@(posedge mclk_in) disable iff (rst_in)
    (ce_in && state_reg == apc_pkg::APC_IDLE && start_req) |=> !busy_l_reg)
    else $error("busy not lowered on start");
  a_no_restart: assert property (@(posedge mclk_in) disable iff (rst_in)
    (ce_in && state_reg == apc_pkg::APC_CONVERT && cnt_reg != 0) |=> state_reg == apc_pkg::APC_CONVERT && cnt_reg == $past(cnt_reg) - 1)
    else $error("conversion restarted");
  a_latch_then_busy: assert property (@(posedge mclk_in) disable iff (rst_in)
    (ce_in && state_reg == apc_pkg::APC_CONVERT && cnt_reg == 0) |=> busy_l_reg && latch_reg == $past(result_bits_in))
    else $error("latch not updated at end");
  a_oe_only_access: assert property (@(posedge mclk_in) disable iff (rst_in)
    (ce_in && !access) |=> oe_reg == 16'h0000)
    else $error("drivers on outside access");
  a_high_byte: assert property (@(posedge mclk_in) disable iff (rst_in)
    (ce_in && access && hb_sel) |=> data_reg[7:0] == {4'h0, $past(latch_reg[11:8])}
      && !($past(state_reg) == apc_pkg::APC_IDLE && state_reg == apc_pkg::APC_CONVERT))
    else $error("high byte read wrong");
  a_nibble_pins: assert property (@(posedge mclk_in) disable iff (rst_in)
    (ce_in && access) |=> data_reg[11:8] == $past(latch_reg[11:8]))
    else $error("upper nibble wrong");
  a_low_byte: assert property (@(posedge mclk_in) disable iff (rst_in)
    (ce_in && access && !hb_sel) |=> data_reg[7:0] == $past(latch_reg[7:0]))
    else $error("low byte wrong");
  a_stall_old_data: assert property (@(posedge mclk_in) disable iff (rst_in)
    (ce_in && stall_wait && access && !hb_sel && cnt_reg != 0)
      |=> data_reg[11:0] == $past(latch_reg))
    else $error("old data not shown during stall");
endmodule
`default_nettype wire

// File: testbench/apc_host_model.sv
// host bus model performing converter read accesses
`timescale 1ns/1ps
`default_nettype none
module apc_host_model
(
  input  wire logic        mclk_in,
  input  wire logic        busy_low_in,
  input  wire logic [15:0] data_in,
  input  wire logic [15:0] oe_in,
  output var  logic        cs_low_out,
  output var  logic        rd_low_out,
  output var  logic        hb_out
);
  // bus idles with select and strobe released
  initial
  begin
    cs_low_out = 1'b1;
    rd_low_out = 1'b1;
    hb_out     = 1'b0;
  end
  // one access; a stalled host waits out busy, gap spaces the next one
  task automatic rd(input logic hb, input bit stall, input int gap,
                    output logic [15:0] d0, output logic [15:0] o0, output logic [15:0] d1);
    int n;
    n = 0;
    @(posedge mclk_in);
    #1;
    cs_low_out = 1'b0;
    rd_low_out = 1'b0;
    hb_out     = hb;
    repeat (8) @(posedge mclk_in);
    #1;
    d0 = data_in;
    o0 = oe_in;
    d1 = data_in;
    // wait state until the result is ready, sampled off the edge
    if (stall)
    begin
      while (busy_low_in !== 1'b1 && n < 1000)
      begin
        @(posedge mclk_in);
        #1;
        n++;
      end
      repeat (2) @(posedge mclk_in);
      #1;
      d1 = data_in;
    end
    cs_low_out = 1'b1;
    rd_low_out = 1'b1;
    repeat (gap) @(posedge mclk_in);
  endtask
endmodule
`default_nettype wire

// File: testbench/apc_control_tb.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
`include "apc_regs.svh"
module apc_control_tb;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        ce = 1'b1;         // clock enable
  int          frz = 0;           // cycles frozen during the running conversion
  logic        mode = 1'b0;       // pipelined mode select
  logic [11:0] res = 12'h000;     // analog core result
  logic [11:0] lat = 12'h000;     // expected output latch
  logic [11:0] nxt = 12'h000;     // result of a pending conversion
  logic [11:0] r;
  logic        cs_low, rd_low, hb, busy_low, sample;
  logic [15:0] data, oe, d0, o0, d1;
  bit          pend = 0;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          convs = 0, run = 0, conv_len = 0, n_exp = 0;
  always #2 mclk_in = ~mclk_in;
  apc_control dut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce),
    .chip_select_low_in(cs_low), .read_strobe_low_in(rd_low), .high_byte_select_in(hb),
    .pipelined_read_mode_in(mode), .result_bits_in(res), .busy_low_out(busy_low),
    .sample_out(sample), .data_out(data), .data_oe_out(oe));
  apc_host_model host (.mclk_in(mclk_in), .busy_low_in(busy_low), .data_in(data),
    .oe_in(oe), .cs_low_out(cs_low), .rd_low_out(rd_low), .hb_out(hb));
  // busy low width and number of latch pulses
  always @(posedge mclk_in)
  begin
    if (rst_in)
      run <= 0;
    else if (busy_low === 1'b0)
      run <= run + 1;
    else if (run != 0)
    begin
      conv_len <= run;
      run <= 0;
    end
    if (!rst_in && sample === 1'b1)
      convs <= convs + 1;
  end
  // bus word expected for a latch value and byte choice
  function automatic logic [15:0] word(input logic [11:0] v, input logic h);
    word = h ? {4'h0, v[11:8], 4'h0, v[11:8]} : {4'h0, v};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic test_done();
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one access with its checks; st says a start is expected
  task automatic step(input logic m, input logic h, input int gap, input logic [11:0] v,
                      input bit st);
    @(posedge mclk_in);
    #1;
    mode = m;
    res  = v;
    host.rd(h, !m && !h, gap, d0, o0, d1);
    chk(d0, word(lat, h), "data at access");
    chk(o0, 16'h0FFF, "enable at access");
    chk(oe, 16'h0000, "enable when idle");
    if (!m && !h)
      chk(d1, word(v, 1'b0), "data after busy");
    if (st)
    begin
      pend = 1;
      nxt  = v;
      n_exp++;
    end
    if (gap > 150 && pend)
    begin
      lat  = nxt;
      pend = 0;
    end
    if (gap > 150)
      chk(16'(convs), 16'(n_exp), "conversion count");
    if (gap > 150 && n_exp > 0)
      chk(16'(conv_len), 16'(`APC_CONV_CYCLES + frz), "busy width");
  endtask
  // main sequence: corner values first, then random values, random mode only for the loop's low byte reads
  initial
  begin
    void'($urandom(57653));
    repeat (20) @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    step(1'b0, 1'b1, 160, 12'hABC, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      r = (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : 12'($urandom);
      step(1'($urandom), 1'b0, 830, r, 1'b1);
      step(1'b1, 1'b1, 160, r, 1'b0);
    end
    // a second start during conversion is ignored
    r = 12'($urandom);
    step(1'b1, 1'b0, 100, r, 1'b1);
    step(1'b1, 1'b0, 830, r, 1'b0);
    // a clock-enable pause freezes the conversion and stretches busy
    r   = 12'($urandom);
    frz = 10;
    fork
      step(1'b1, 1'b0, 830, r, 1'b1);
      begin
        repeat (100) @(posedge mclk_in);
        #1;
        ce = 1'b0;
        repeat (frz) @(posedge mclk_in);
        #1;
        ce = 1'b1;
      end
    join
    frz = 0;
    step(1'b0, 1'b0, 160, 12'($urandom), 1'b1);
    test_done();
  end
  // cuts a hang short
  initial
  begin
    #(4 * 40000);
    num_errors++;
    $display("mismatch at %0t: timeout", $time);
    test_done();
  end
endmodule
`default_nettype wire
